//--- design/ccp_pkg.sv
// constants, register map and state types of the clock and power controller
// Function
// - after any reset the cpu runs from the internal RC oscillator until software switches
// - software may select internal RC, main or RTC oscillator as pll input
// - internal RC runs nominally at 4 MHz; wake-up counts assume that rate
// - pll input pre-divider N is programmable from 1 to 256
// - multiplier M spans 1 to 32768; software keeps the oscillator in 275-550 MHz
// - cpu clock equals pll input unless the pll is active and connected
// - reset and power-down disable and bypass the pll; only software re-enables
// - power-up and power-down wake restart from the internal RC oscillator
// - a wake-up timer qualifies the main oscillator before it may clock the cpu
// - idle halts execution until reset or interrupt; peripheral clocks keep running
// - sleep stops the oscillator and gates every internal clock; state is kept
// - sleep gates internal RC output but keeps it powered; RTC oscillator runs
// - sleep entry turns off and disconnects the pll and zeroes cpu/usb dividers
// - sleep ends only by reset or clockless wake interrupt; flash stays powered
// - sleep wake resumes after 4 internal RC cycles, or 4096 main cycles
// - power-down does all sleep actions and also powers off internal RC and flash
// - power-down wake allows 60 us RC start, then 4 RC cycles before resuming
// - flash counter covers 100 us after power-down wake; flash blocked until then
// - each peripheral has its own software clock gate and clock divider
package ccp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned RCO_KHZ = 4000;
  localparam int unsigned MAIN_OSC_KHZ = 12000;
  localparam int unsigned RCO_PERIOD_NS = 1000000 / RCO_KHZ;
  localparam int unsigned RCO_CYC =
    (RCO_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESUME_RCO_CYCLES_OF_RCO = 4;
  localparam int unsigned RESUME_RCO_CYC = RESUME_RCO_CYCLES_OF_RCO * RCO_CYC;
  localparam int unsigned MAIN_WAKE_CYCLES_OF_MAIN = 4096;
  localparam int unsigned MAIN_WAKE_CYC =
    (MAIN_WAKE_CYCLES_OF_MAIN * 125000) / MAIN_OSC_KHZ;
  localparam int unsigned RCO_START_US = 60;
  localparam int unsigned RCO_START_CYC =
    (RCO_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FLASH_START_US = 100;
  localparam int unsigned FLASH_START_CYC =
    (FLASH_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SWITCH_HOLD_CYC = 2 * RCO_CYC;
  localparam int unsigned NUM_PERIPH = 16;
  localparam int unsigned CNT_W = 16;

  localparam logic [7:0] OFS_CLKSRC = 8'h00;
  localparam logic [7:0] OFS_PLLCFG = 8'h04;
  localparam logic [7:0] OFS_PLLCTRL = 8'h08;
  localparam logic [7:0] OFS_PLLSTAT = 8'h0c;
  localparam logic [7:0] OFS_CPUDIV = 8'h10;
  localparam logic [7:0] OFS_USBDIV = 8'h14;
  localparam logic [7:0] OFS_PGATE = 8'h18;
  localparam logic [7:0] OFS_PDIV = 8'h1c;
  localparam logic [7:0] OFS_PMODE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_OSCCTRL = 8'h28;

  localparam int unsigned PLLCFG_M_LSB = 0;
  localparam int unsigned PLLCFG_N_LSB = 16;
  localparam logic [15:0] PGATE_RESET = 16'hffff;

  typedef enum logic [1:0] {
    CCP_SRC_RCO = 2'b00,
    CCP_SRC_MAIN = 2'b01,
    CCP_SRC_RTC = 2'b10
  } ccp_src_type;

  typedef enum logic [1:0] {
    CCP_CMD_RUN = 2'b00,
    CCP_CMD_IDLE = 2'b01,
    CCP_CMD_SLEEP = 2'b10,
    CCP_CMD_PDOWN = 2'b11
  } ccp_cmd_type;

  typedef enum logic [2:0] {
    CCP_PM_RUN = 3'b000,
    CCP_PM_IDLE = 3'b001,
    CCP_PM_SLEEP = 3'b010,
    CCP_PM_PDOWN = 3'b011,
    CCP_PM_RCO_START = 3'b100,
    CCP_PM_RESUME = 3'b101
  } ccp_pm_type;

  typedef enum logic [1:0] {
    CCP_SW_IDLE = 2'b00,
    CCP_SW_GATE = 2'b01,
    CCP_SW_SETTLE = 2'b10
  } ccp_sw_type;
endpackage

//--- design/ccp_clock_power.sv
// clock source, pll control, peripheral clock gating and power-mode sequencer
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
module ccp_clock_power #(
  parameter int unsigned RCO_START_CYCLES = ccp_pkg::RCO_START_CYC,
  parameter int unsigned FLASH_START_CYCLES = ccp_pkg::FLASH_START_CYC,
  parameter int unsigned MAIN_WAKE_CYCLES = ccp_pkg::MAIN_WAKE_CYC
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pll_lock_i,
  input wire logic irq_any_i,
  input wire logic wake_irq_i,
  output logic [1:0] clk_src_sel_o,
  output logic [7:0] pll_pre_div_o,
  output logic [14:0] pll_mult_o,
  output logic pll_enable_o,
  output logic pll_connect_o,
  output logic [7:0] cpu_clk_div_o,
  output logic [3:0] usb_clk_div_o,
  output logic cpu_clk_en_o,
  output logic [ccp_pkg::NUM_PERIPH-1:0] periph_clk_en_o,
  output logic [2*ccp_pkg::NUM_PERIPH-1:0] periph_clk_div_o,
  output logic main_osc_en_o,
  output logic irc_power_o,
  output logic irc_out_en_o,
  output logic flash_power_o,
  output logic flash_ready_o,
  output logic [2:0] pm_state_o
);
  localparam logic [ccp_pkg::CNT_W-1:0] RCO_START_N =
    ccp_pkg::CNT_W'(RCO_START_CYCLES - 1);
  localparam logic [ccp_pkg::CNT_W-1:0] FLASH_START_N =
    ccp_pkg::CNT_W'(FLASH_START_CYCLES - 1);
  localparam logic [ccp_pkg::CNT_W-1:0] MAIN_WAKE_N =
    ccp_pkg::CNT_W'(MAIN_WAKE_CYCLES - 1);
  localparam logic [ccp_pkg::CNT_W-1:0] RESUME_RCO_N =
    ccp_pkg::CNT_W'(ccp_pkg::RESUME_RCO_CYC - 1);
  localparam logic [ccp_pkg::CNT_W-1:0] SWITCH_HOLD_N =
    ccp_pkg::CNT_W'(ccp_pkg::SWITCH_HOLD_CYC - 1);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  ccp_pkg::ccp_pm_type pm_q;
  ccp_pkg::ccp_sw_type sw_q;
  ccp_pkg::ccp_src_type src_req_q;
  ccp_pkg::ccp_src_type src_act_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] pll_n_q;
  logic [14:0] pll_m_q;
  logic pll_en_q;
  logic pll_conn_q;
  logic conn_act_q;
  logic [7:0] cpu_div_q;
  logic [3:0] usb_div_q;
  logic [15:0] pgate_q;
  logic [31:0] pdiv_q;
  logic main_en_q;
  logic main_ok_q;
  logic [ccp_pkg::CNT_W-1:0] main_cnt_q;
  logic [ccp_pkg::CNT_W-1:0] pm_cnt_q;
  logic [ccp_pkg::CNT_W-1:0] sw_cnt_q;
  logic [ccp_pkg::CNT_W-1:0] fl_cnt_q;
  logic flash_pwr_q;
  logic flash_rdy_q;
  logic cpu_en_q;
  logic [ccp_pkg::NUM_PERIPH-1:0] pclk_en_q;
  logic wb_req;
  logic wr;
  logic [31:0] rsel;
  logic [31:0] pllcfg_w;
  logic [31:0] m_word;
  logic [31:0] pgate_w;
  logic enter_idle;
  logic enter_sleep;
  logic enter_pd;
  logic stop_entry;
  logic clocks_on;
  ccp_pkg::ccp_src_type src_tgt;
  logic conn_tgt;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = wb_req & wb_we_i;
  assign m_word = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign pllcfg_w = merge({8'h00, pll_n_q, 1'b0, pll_m_q}, wb_dat_i, wb_sel_i);
  assign pgate_w = merge({16'h0, pgate_q}, wb_dat_i, wb_sel_i);
  assign enter_idle = wr & (wb_adr_i == ccp_pkg::OFS_PMODE) & wb_sel_i[0]
    & (m_word[1:0] == ccp_pkg::CCP_CMD_IDLE) & (pm_q == ccp_pkg::CCP_PM_RUN);
  assign enter_sleep = wr & (wb_adr_i == ccp_pkg::OFS_PMODE) & wb_sel_i[0]
    & (m_word[1:0] == ccp_pkg::CCP_CMD_SLEEP) & (pm_q == ccp_pkg::CCP_PM_RUN);
  assign enter_pd = wr & (wb_adr_i == ccp_pkg::OFS_PMODE) & wb_sel_i[0]
    & (m_word[1:0] == ccp_pkg::CCP_CMD_PDOWN) & (pm_q == ccp_pkg::CCP_PM_RUN);
  assign stop_entry = enter_sleep | enter_pd;
  assign clocks_on = (pm_q == ccp_pkg::CCP_PM_RUN)
    | (pm_q == ccp_pkg::CCP_PM_IDLE);

  // wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wb_req;
      if (wb_req)
      begin
        rdata_q <= rsel;
      end
    end
  end

  always_comb
  begin
    rsel = 32'h0000_0000;
    unique case (wb_adr_i)
      ccp_pkg::OFS_CLKSRC: rsel = {30'h0, src_req_q};
      ccp_pkg::OFS_PLLCFG: rsel = {8'h00, pll_n_q, 1'b0, pll_m_q};
      ccp_pkg::OFS_PLLCTRL: rsel = {30'h0, pll_conn_q, pll_en_q};
      ccp_pkg::OFS_PLLSTAT: rsel = {27'h0, src_act_q, pll_lock_i, conn_act_q,
                                    pll_en_q};
      ccp_pkg::OFS_CPUDIV: rsel = {24'h0, cpu_div_q};
      ccp_pkg::OFS_USBDIV: rsel = {28'h0, usb_div_q};
      ccp_pkg::OFS_PGATE: rsel = {16'h0, pgate_q};
      ccp_pkg::OFS_PDIV: rsel = pdiv_q;
      ccp_pkg::OFS_STATUS: rsel = {26'h0, flash_rdy_q, main_ok_q, 1'b0, pm_q};
      ccp_pkg::OFS_OSCCTRL: rsel = {31'h0, main_en_q};
      default: rsel = 32'h0000_0000;
    endcase
  end

  // clock source request; reset and power-down fall back to the RC oscillator
  always_ff @(posedge clk)
  begin
    if (rst | enter_pd)
    begin
      src_req_q <= ccp_pkg::CCP_SRC_RCO;
    end
    else if (wr & (wb_adr_i == ccp_pkg::OFS_CLKSRC) & wb_sel_i[0]
             & (m_word[1:0] != 2'b11))
    begin
      src_req_q <= ccp_pkg::ccp_src_type'(m_word[1:0]);
    end
  end

  // pll configuration: stored as divider-1 and multiplier-1
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pll_n_q <= 8'h00;
      pll_m_q <= 15'h0000;
    end
    else if (wr & (wb_adr_i == ccp_pkg::OFS_PLLCFG))
    begin
      pll_n_q <= pllcfg_w[ccp_pkg::PLLCFG_N_LSB +: 8];
      pll_m_q <= pllcfg_w[ccp_pkg::PLLCFG_M_LSB +: 15];
    end
  end

  // pll enable/connect, cleared by reset, sleep and power-down entry
  always_ff @(posedge clk)
  begin
    if (rst | stop_entry)
    begin
      pll_en_q <= 1'b0;
      pll_conn_q <= 1'b0;
    end
    else if (wr & (wb_adr_i == ccp_pkg::OFS_PLLCTRL) & wb_sel_i[0])
    begin
      pll_en_q <= m_word[0];
      pll_conn_q <= m_word[1];
    end
  end

  // cpu and usb dividers zeroed on stop entry
  always_ff @(posedge clk)
  begin
    if (rst | stop_entry)
    begin
      cpu_div_q <= 8'h00;
      usb_div_q <= 4'h0;
    end
    else if (wr & (wb_adr_i == ccp_pkg::OFS_CPUDIV) & wb_sel_i[0])
    begin
      cpu_div_q <= m_word[7:0];
    end
    else if (wr & (wb_adr_i == ccp_pkg::OFS_USBDIV) & wb_sel_i[0])
    begin
      usb_div_q <= m_word[3:0];
    end
  end

  // peripheral gates and dividers; kept through sleep
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pgate_q <= ccp_pkg::PGATE_RESET;
      pdiv_q <= 32'h0000_0000;
    end
    else if (wr & (wb_adr_i == ccp_pkg::OFS_PGATE))
    begin
      pgate_q <= pgate_w[15:0];
    end
    else if (wr & (wb_adr_i == ccp_pkg::OFS_PDIV))
    begin
      pdiv_q <= merge(pdiv_q, wb_dat_i, wb_sel_i);
    end
  end

  // main oscillator enable; the oscillator stops in sleep and power-down
  always_ff @(posedge clk)
  begin
    if (rst | stop_entry)
    begin
      main_en_q <= 1'b0;
    end
    else if (wr & (wb_adr_i == ccp_pkg::OFS_OSCCTRL) & wb_sel_i[0])
    begin
      main_en_q <= m_word[0];
    end
  end

  // wake-up timer qualifying the main oscillator after each start
  always_ff @(posedge clk)
  begin
    if (rst | ~main_en_q)
    begin
      main_cnt_q <= '0;
      main_ok_q <= 1'b0;
    end
    else if (~main_ok_q)
    begin
      if (main_cnt_q == MAIN_WAKE_N)
      begin
        main_ok_q <= 1'b1;
      end
      else
      begin
        main_cnt_q <= main_cnt_q + 1'b1;
      end
    end
  end

  // main oscillator is used only once qualified; pll only when locked
  assign src_tgt = (src_req_q == ccp_pkg::CCP_SRC_MAIN & ~main_ok_q)
    ? src_act_q : src_req_q;
  assign conn_tgt = pll_conn_q & pll_en_q & pll_lock_i;

  // glitch-free switcher: gate the cpu clock, change, settle, ungate
  always_ff @(posedge clk)
  begin
    if (rst | enter_pd)
    begin
      sw_q <= ccp_pkg::CCP_SW_IDLE;
      sw_cnt_q <= '0;
      src_act_q <= ccp_pkg::CCP_SRC_RCO;
      conn_act_q <= 1'b0;
    end
    else if (enter_sleep | (~pll_en_q & conn_act_q))
    begin
      sw_q <= ccp_pkg::CCP_SW_IDLE;
      sw_cnt_q <= '0;
      conn_act_q <= 1'b0;
    end
    else
    begin
      unique case (sw_q)
        ccp_pkg::CCP_SW_IDLE:
        begin
          if ((pm_q == ccp_pkg::CCP_PM_RUN)
              & ((src_tgt != src_act_q) | (conn_tgt != conn_act_q)))
          begin
            sw_q <= ccp_pkg::CCP_SW_GATE;
            sw_cnt_q <= '0;
          end
        end
        ccp_pkg::CCP_SW_GATE:
        begin
          if (sw_cnt_q == SWITCH_HOLD_N)
          begin
            src_act_q <= src_tgt;
            conn_act_q <= conn_tgt;
            sw_q <= ccp_pkg::CCP_SW_SETTLE;
            sw_cnt_q <= '0;
          end
          else
          begin
            sw_cnt_q <= sw_cnt_q + 1'b1;
          end
        end
        ccp_pkg::CCP_SW_SETTLE:
        begin
          if (sw_cnt_q == SWITCH_HOLD_N)
          begin
            sw_q <= ccp_pkg::CCP_SW_IDLE;
          end
          else
          begin
            sw_cnt_q <= sw_cnt_q + 1'b1;
          end
        end
        default: sw_q <= ccp_pkg::CCP_SW_IDLE;
      endcase
    end
  end

  // power-mode sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pm_q <= ccp_pkg::CCP_PM_RUN;
      pm_cnt_q <= '0;
    end
    else
    begin
      unique case (pm_q)
        ccp_pkg::CCP_PM_RUN:
        begin
          pm_cnt_q <= '0;
          if (enter_idle)
          begin
            pm_q <= ccp_pkg::CCP_PM_IDLE;
          end
          else if (enter_sleep)
          begin
            pm_q <= ccp_pkg::CCP_PM_SLEEP;
          end
          else if (enter_pd)
          begin
            pm_q <= ccp_pkg::CCP_PM_PDOWN;
          end
        end
        ccp_pkg::CCP_PM_IDLE:
        begin
          if (irq_any_i)
          begin
            pm_q <= ccp_pkg::CCP_PM_RUN;
          end
        end
        ccp_pkg::CCP_PM_SLEEP:
        begin
          if (wake_irq_i)
          begin
            pm_q <= ccp_pkg::CCP_PM_RESUME;
            pm_cnt_q <= (src_act_q == ccp_pkg::CCP_SRC_MAIN)
              ? MAIN_WAKE_N : RESUME_RCO_N;
          end
        end
        ccp_pkg::CCP_PM_PDOWN:
        begin
          if (wake_irq_i)
          begin
            pm_q <= ccp_pkg::CCP_PM_RCO_START;
            pm_cnt_q <= RCO_START_N;
          end
        end
        ccp_pkg::CCP_PM_RCO_START:
        begin
          if (pm_cnt_q == '0)
          begin
            pm_q <= ccp_pkg::CCP_PM_RESUME;
            pm_cnt_q <= RESUME_RCO_N;
          end
          else
          begin
            pm_cnt_q <= pm_cnt_q - 1'b1;
          end
        end
        ccp_pkg::CCP_PM_RESUME:
        begin
          if (pm_cnt_q == '0)
          begin
            pm_q <= ccp_pkg::CCP_PM_RUN;
          end
          else
          begin
            pm_cnt_q <= pm_cnt_q - 1'b1;
          end
        end
        default: pm_q <= ccp_pkg::CCP_PM_RUN;
      endcase
    end
  end

  // flash power and wake-up counter after power-down
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flash_pwr_q <= 1'b1;
      flash_rdy_q <= 1'b1;
      fl_cnt_q <= '0;
    end
    else if (enter_pd)
    begin
      flash_pwr_q <= 1'b0;
      flash_rdy_q <= 1'b0;
    end
    else if ((pm_q == ccp_pkg::CCP_PM_PDOWN) & wake_irq_i)
    begin
      flash_pwr_q <= 1'b1;
      fl_cnt_q <= FLASH_START_N;
    end
    else if (flash_pwr_q & ~flash_rdy_q)
    begin
      if (fl_cnt_q == '0)
      begin
        flash_rdy_q <= 1'b1;
      end
      else
      begin
        fl_cnt_q <= fl_cnt_q - 1'b1;
      end
    end
  end

  // cpu clock enable: off outside run and while the switcher holds it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cpu_en_q <= 1'b1;
    end
    else
    begin
      cpu_en_q <= (pm_q == ccp_pkg::CCP_PM_RUN) & ~stop_entry & ~enter_idle
        & ~((sw_q == ccp_pkg::CCP_SW_IDLE)
            & ((src_tgt != src_act_q) | (conn_tgt != conn_act_q)))
        & (sw_q == ccp_pkg::CCP_SW_IDLE);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ccp_pkg::NUM_PERIPH; gi++)
    begin : g_pclk
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          pclk_en_q[gi] <= 1'b1;
        end
        else
        begin
          pclk_en_q[gi] <= pgate_q[gi] & clocks_on & ~stop_entry;
        end
      end
      assign periph_clk_div_o[2*gi +: 2] = pdiv_q[2*gi +: 2];
    end
  endgenerate

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign clk_src_sel_o = src_act_q;
  assign pll_pre_div_o = pll_n_q;
  assign pll_mult_o = pll_m_q;
  assign pll_enable_o = pll_en_q;
  assign pll_connect_o = conn_act_q;
  assign cpu_clk_div_o = cpu_div_q;
  assign usb_clk_div_o = usb_div_q;
  assign cpu_clk_en_o = cpu_en_q;
  assign periph_clk_en_o = pclk_en_q;
  assign main_osc_en_o = main_en_q;
  // rc stays powered in sleep, output gated until the core resumes
  assign irc_power_o = (pm_q != ccp_pkg::CCP_PM_PDOWN);
  assign irc_out_en_o = clocks_on | (pm_q == ccp_pkg::CCP_PM_RESUME);
  assign flash_power_o = flash_pwr_q;
  assign flash_ready_o = flash_rdy_q;
  assign pm_state_o = pm_q;
endmodule

//--- verification/ccp_clock_power_sva.sv
// assertion checker watching the clock and power controller ports
`timescale 1ns/10ps
module ccp_clock_power_sva #(
  parameter int unsigned RCO_START_CYCLES = 20
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic pll_lock_i,
  input wire logic irq_any_i,
  input wire logic wake_irq_i,
  input wire logic [1:0] clk_src_sel_o,
  input wire logic pll_enable_o,
  input wire logic pll_connect_o,
  input wire logic [7:0] cpu_clk_div_o,
  input wire logic [3:0] usb_clk_div_o,
  input wire logic cpu_clk_en_o,
  input wire logic irc_power_o,
  input wire logic irc_out_en_o,
  input wire logic flash_power_o,
  input wire logic flash_ready_o,
  input wire logic [2:0] pm_state_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // cycles spent in the present power state
  logic [15:0] dwell_q;
  always_ff @(posedge clk)
  begin
    if (rst || $changed(pm_state_o))
      dwell_q <= 16'h0;
    else
      dwell_q <= dwell_q + 16'h1;
  end
  a_reset_to_rc: assert property ($fell(rst) |-> clk_src_sel_o == 2'h0
    && !pll_enable_o && !pll_connect_o && pm_state_o == 3'h0)
    else $error("reset did not restore rc source with pll off");
  a_connect_locked: assert property ($rose(pll_connect_o) |->
    pll_lock_i && pll_enable_o)
    else $error("pll connected without lock or enable");
  a_switch_gated: assert property (pm_state_o == 3'h0 &&
    ($rose(pll_connect_o) || $changed(clk_src_sel_o)) |-> !cpu_clk_en_o)
    else $error("clock changed while cpu clock running");
  a_gate_span: assert property ($fell(cpu_clk_en_o) &&
    pm_state_o == 3'h0 |-> !cpu_clk_en_o [*8])
    else $error("cpu clock gate reopened too soon");
  a_sleep_entry: assert property ($changed(pm_state_o) &&
    pm_state_o == 3'h2 |-> !pll_enable_o && !pll_connect_o &&
    cpu_clk_div_o == 8'h0 && usb_clk_div_o == 4'h0 && !irc_out_en_o &&
    irc_power_o && flash_power_o)
    else $error("sleep entry left clocks or dividers set");
  a_pdown_off: assert property (pm_state_o == 3'h3 |-> !irc_power_o &&
    !flash_power_o && !flash_ready_o && clk_src_sel_o == 2'h0 && !pll_enable_o)
    else $error("power-down left rc, flash or pll on");
  a_idle_state: assert property (pm_state_o == 3'h1 |->
    !cpu_clk_en_o && irc_out_en_o)
    else $error("idle state clocks wrong");
  a_idle_exit: assert property (pm_state_o == 3'h1 && irq_any_i |->
    ##[1:2] pm_state_o == 3'h0)
    else $error("interrupt did not end idle");
  a_sleep_hold: assert property (pm_state_o == 3'h2 && !wake_irq_i |=>
    pm_state_o == 3'h2)
    else $error("sleep left without wake interrupt");
  a_rc_start: assert property (pm_state_o == 3'h5 &&
    $past(pm_state_o) == 3'h4 |-> $past(dwell_q) + 2 >= RCO_START_CYCLES &&
    $past(dwell_q) <= RCO_START_CYCLES + 2)
    else $error("rc start-up wait has wrong length");
  a_flash_block: assert property (pm_state_o == 3'h4 |-> !flash_ready_o)
    else $error("flash ready during rc start-up");
endmodule
bind ccp_clock_power ccp_clock_power_sva #(
  .RCO_START_CYCLES(RCO_START_CYCLES)
) u_sva (.clk(clk), .rst(rst), .pll_lock_i(pll_lock_i),
  .irq_any_i(irq_any_i), .wake_irq_i(wake_irq_i),
  .clk_src_sel_o(clk_src_sel_o), .pll_enable_o(pll_enable_o),
  .pll_connect_o(pll_connect_o), .cpu_clk_div_o(cpu_clk_div_o),
  .usb_clk_div_o(usb_clk_div_o), .cpu_clk_en_o(cpu_clk_en_o),
  .irc_power_o(irc_power_o), .irc_out_en_o(irc_out_en_o),
  .flash_power_o(flash_power_o), .flash_ready_o(flash_ready_o),
  .pm_state_o(pm_state_o));

//--- verification/tb_clock_source_pll_power_modes.sv
// self-checking bench for the clock and power controller
`timescale 1ns/10ps
module tb_clock_source_pll_power_modes;
  localparam int IS = 20;
  localparam int FS = 30;
  localparam int MW = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, lock = 1'b0, irq = 1'b0;
  logic wake_irq = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, q, pdiv;
  logic ack, pll_en, pll_conn, cpu_en, osc_en, irc_pwr, irc_out, fl_pwr, fl_rdy;
  logic [1:0] src;
  logic [7:0] pre_div, cpu_div;
  logic [14:0] mult;
  logic [3:0] usb_div;
  logic [15:0] pgate;
  logic [2:0] pm;
  int n_mismatch = 0, checks = 0, cyc_n = 0, n, f;
  // address, write data, expected read-back
  logic [71:0] rows [8] = '{
    {8'h04, 32'h00ff7fff, 32'h00ff7fff}, {8'h10, 32'h000000ff, 32'h000000ff},
    {8'h14, 32'h0000000f, 32'h0000000f}, {8'h18, 32'h00001234, 32'h00001234},
    {8'h1c, 32'ha5a5c3c3, 32'ha5a5c3c3}, {8'h0c, 32'h0000001f, 32'h00000000},
    {8'h3c, 32'hffffffff, 32'h00000000}, {8'h00, 32'h00000003, 32'h00000000}};

  ccp_clock_power #(.RCO_START_CYCLES(IS), .FLASH_START_CYCLES(FS),
    .MAIN_WAKE_CYCLES(MW)) uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pll_lock_i(lock),
    .irq_any_i(irq), .wake_irq_i(wake_irq), .clk_src_sel_o(src),
    .pll_pre_div_o(pre_div), .pll_mult_o(mult), .pll_enable_o(pll_en),
    .pll_connect_o(pll_conn), .cpu_clk_div_o(cpu_div), .usb_clk_div_o(usb_div),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(pgate), .periph_clk_div_o(pdiv),
    .main_osc_en_o(osc_en), .irc_power_o(irc_pwr), .irc_out_en_o(irc_out),
    .flash_power_o(fl_pwr), .flash_ready_o(fl_rdy), .pm_state_o(pm));

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  // one classic cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && t < 50)
    begin
      @(posedge clk);
      t++;
    end
    chk("wb_ack_o", ack, 1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // pulse the clockless wake line and time the way back to run
  task automatic wake();
    n = 0;
    f = 0;
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    while (pm !== 3'h0 && n < 3000)
    begin
      @(posedge clk);
      n++;
      if (f == 0 && fl_rdy === 1'b1)
        f = n;
    end
  endtask

  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    tick(10);
    rst <= 1'b0;
    tick(1);
    chk("src", src, 0);
    chk("pll", {pll_en, pll_conn}, 0);
    chk("run", {cpu_en, pgate, fl_rdy, irc_pwr, osc_en}, 32'hffffe);
    foreach (rows[i])
    begin
      wb(1'b1, rows[i][71:64], rows[i][63:32]);
      wb(1'b0, rows[i][71:64], 32'h0);
      chk("read_back", q, rows[i][31:0]);
    end
    chk("pre_div_mult", {pre_div, mult}, {8'hff, 15'h7fff});
    chk("pgate", {pgate, usb_div, cpu_div}, 28'h1234fff);
    chk("pdiv", pdiv, 32'ha5a5c3c3);
    wb(1'b1, 8'h08, 32'h3);
    tick(200);
    chk("pll_conn", pll_conn, 0);
    lock <= 1'b1;
    wb(1'b1, 8'h08, 32'h3);
    tick(200);
    chk("pll_run", {pll_en, pll_conn, cpu_en}, 3'h7);
    wb(1'b0, 8'h0c, 32'h0);
    chk("pll_stat", q[2:0], 3'h7);
    wb(1'b1, 8'h00, 32'h2);
    tick(200);
    chk("src", src, 2'h2);
    wb(1'b1, 8'h00, 32'h1);
    tick(200);
    chk("src", src, 2'h2);
    wb(1'b1, 8'h28, 32'h1);
    tick(MW + 200);
    chk("src", src, 2'h1);
    wb(1'b1, 8'h20, 32'h1);
    tick(5);
    chk("idle", {pm, cpu_en, pgate}, {3'h1, 1'b0, 16'h1234});
    irq <= 1'b1;
    tick(3);
    irq <= 1'b0;
    chk("pm", pm, 3'h0);
    wb(1'b1, 8'h20, 32'h2);
    tick(5);
    chk("sleep", {pll_en, pll_conn, cpu_div, usb_div, osc_en}, 0);
    chk("gates", {cpu_en, pgate, irc_out, irc_pwr, fl_rdy}, 3'h3);
    wake();
    chk("main_resume", n >= MW && n <= MW + 6, 1);
    chk("src", src, 2'h1);
    wb(1'b1, 8'h20, 32'h3);
    tick(5);
    chk("pdown", {irc_pwr, fl_pwr, fl_rdy, src}, 0);
    wake();
    chk("rc_resume", n >= IS + 128 && n <= IS + 134, 1);
    chk("flash_wait", f >= FS && f <= FS + 4, 1);
    wb(1'b1, 8'h20, 32'h2);
    tick(5);
    wake();
    chk("rc_resume", n >= 128 && n <= 134, 1);
    wb(1'b1, 8'h00, 32'h2);
    tick(200);
    chk("src_pll_off", src, 2'h2);
    wb(1'b1, 8'h08, 32'h1);
    tick(200);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    chk("reset_again", {src, pll_en}, 0);
    close_out();
  end
endmodule
